// *** core/rtsl_defs.vh ***
// Constants for the two-wire slave of the clock/calendar block.
// Assumes inclusion by bare name from the core/ design files and the top bench.
`ifndef RTSL_DEFS_VH
`define RTSL_DEFS_VH

// ------------------------------------------------------------
// Addressing
// ------------------------------------------------------------
`define RTSL_SLAVE_ADDR  7'h68
`define RTSL_PTR_LAST    6'h3F
`define RTSL_PTR_FIRST   6'h00
`define RTSL_PTR_RESET   6'h00

// ------------------------------------------------------------
// Field positions and sizes
// ------------------------------------------------------------
`define RTSL_DIR_BIT     0
`define RTSL_PTR_MSB     5
`define RTSL_BIT_LAST    3'h7

`endif

// *** core/rtsl_sync.v ***
// Two-stage synchroniser plus edge detect for one bus line.
// Assumes an asynchronous input and core_clk much faster than the line.
module rtsl_sync (
  input  wire core_clk,
  input  wire nrst,
  input  wire line_in,
  output reg  level_reg,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;

  // ------------------------------------------------------------
  // Synchroniser and history
  // ------------------------------------------------------------
  // First stage feeds only the second; idle line resets high
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg  <= 1'b1;
      sync_reg  <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      meta_reg  <= line_in;
      sync_reg  <= meta_reg;
      level_reg <= sync_reg;
    end
  end

  // Edges compare the second stage with its delayed copy
  assign rise = sync_reg & ~level_reg;
  assign fall = ~sync_reg & level_reg;

endmodule // rtsl_sync

// *** core/rtsl_shift.v ***
// Eight-bit shift register for bytes moving MSB first.
// Assumes strobes are single core_clk pulses from the main FSM.
module rtsl_shift (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       load,
  input  wire [7:0] load_data,
  input  wire       shift,
  input  wire       shift_in,
  output reg  [7:0] data_reg
);

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  // Load wins over shift; a shift moves one bit in at the LSB
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= 8'h00;
    end else if (load) begin
      data_reg <= load_data;
    end else if (shift) begin
      data_reg <= {data_reg[6:0], shift_in};
    end
  end

endmodule // rtsl_shift

// *** core/rtsl_slave.v ***
// Two-wire bus slave: address match, register pointer, byte moves.
// Assumes a bus master clocking at or below standard rate; the
// register file and snapshot logic sit outside, on reg_ptr/rd_data.
`include "rtsl_defs.vh"

module rtsl_slave (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  output reg  [5:0] reg_ptr,
  input  wire [7:0] rd_data,
  output reg  [7:0] wr_data,
  output reg        wr_strobe,
  output reg        snap_strobe,
  output reg        busy
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WBYTE = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RBYTE = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;

  // Next pointer with wrap at the end of RAM space
  function [5:0] ptr_inc;
    input [5:0] p;
    begin
      if (p == `RTSL_PTR_LAST) begin
        ptr_inc = `RTSL_PTR_FIRST;
      end else begin
        ptr_inc = p + 6'h01;
      end
    end
  endfunction

  wire       scl_lvl;
  wire       scl_rise;
  wire       scl_fall;
  wire       sda_lvl;
  wire       sda_rise;
  wire       sda_fall;
  wire [7:0] sh_data;

  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [2:0] bit_reg;
  reg  [2:0] bit_next;
  reg        ptr_done_reg;
  reg        ptr_done_next;
  reg        drive_low_reg;
  reg        drive_low_next;
  reg  [5:0] ptr_next;
  reg        sh_load;
  reg  [7:0] sh_load_data;
  reg        sh_shift;
  reg        wr_strobe_next;
  reg  [7:0] wr_data_next;
  reg        start_det;
  reg        stop_det;
  reg        byte_ready_reg;
  reg        wr_data_pend_reg;

  // ------------------------------------------------------------
  // Line synchronisers and shift register
  // ------------------------------------------------------------
  rtsl_sync u_scl (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .line_in   (scl_in),
    .level_reg (scl_lvl),
    .rise      (scl_rise),
    .fall      (scl_fall)
  );

  rtsl_sync u_sda (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .line_in   (sda_in),
    .level_reg (sda_lvl),
    .rise      (sda_rise),
    .fall      (sda_fall)
  );

  rtsl_shift u_shift (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .load      (sh_load),
    .load_data (sh_load_data),
    .shift     (sh_shift),
    .shift_in  (sda_lvl),
    .data_reg  (sh_data)
  );

  // ------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------
  // START and STOP detect
  // data edges with clock high are conditions, not data
  always @* begin
    start_det = sda_fall & scl_lvl & ~scl_fall;
    stop_det  = sda_rise & scl_lvl & ~scl_fall;
  end

  // ------------------------------------------------------------
  // Transfer state machine
  // ------------------------------------------------------------
  // Bits are sampled on clock rise; the line is changed on clock
  // fall, so our output never moves while the clock is high.
  always @* begin
    state_next     = state_reg;
    bit_next       = bit_reg;
    ptr_done_next  = ptr_done_reg;
    drive_low_next = drive_low_reg;
    ptr_next       = reg_ptr;
    sh_load        = 1'b0;
    sh_load_data   = 8'h00;
    sh_shift       = 1'b0;
    wr_strobe_next = 1'b0;
    wr_data_next   = wr_data;
    if (start_det) begin
      state_next     = ST_ADDR;
      bit_next       = 3'h0;
      drive_low_next = 1'b0;
    end else if (stop_det) begin
      state_next     = ST_IDLE;
      drive_low_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          drive_low_next = 1'b0;
        end
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            sh_shift = 1'b1;
            bit_next = bit_reg + 3'h1;
          end
          if (scl_fall && bit_reg == 3'h0 && byte_ready_reg) begin
            bit_next = 3'h0;
            if (state_reg == ST_ADDR) begin
              if (sh_data[7:1] == `RTSL_SLAVE_ADDR) begin
                state_next     = ST_AACK;
                drive_low_next = 1'b1;
              end else begin
                state_next = ST_IDLE;
              end
            end else begin
              state_next     = ST_WACK;
              drive_low_next = 1'b1;
              if (!ptr_done_reg) begin
                ptr_next      = sh_data[`RTSL_PTR_MSB:0];
                ptr_done_next = 1'b1;
              end else begin
                wr_strobe_next = 1'b1;
                wr_data_next   = sh_data;
              end
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (sh_data[`RTSL_DIR_BIT]) begin
              // read mode; start at held pointer
              state_next     = ST_RBYTE;
              sh_load        = 1'b1;
              sh_load_data   = rd_data;
              drive_low_next = ~rd_data[7];
              bit_next       = 3'h0;
            end else begin
              state_next     = ST_WBYTE;
              drive_low_next = 1'b0;
              ptr_done_next  = 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_next     = ST_WBYTE;
            drive_low_next = 1'b0;
            if (wr_data_pend_reg) begin
              ptr_next = ptr_inc(reg_ptr);
            end
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_reg == `RTSL_BIT_LAST) begin
              state_next     = ST_RACK;
              drive_low_next = 1'b0;
              ptr_next       = ptr_inc(reg_ptr);
            end else begin
              bit_next       = bit_reg + 3'h1;
              sh_shift       = 1'b1;
              drive_low_next = ~sh_data[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_lvl) begin
              state_next = ST_IDLE;
            end
          end else if (scl_fall) begin
            state_next     = ST_RBYTE;
            sh_load        = 1'b1;
            sh_load_data   = rd_data;
            drive_low_next = ~rd_data[7];
            bit_next       = 3'h0;
          end
        end
        default: begin
          state_next     = ST_IDLE;
          drive_low_next = 1'b0;
        end
      endcase
    end
  end

  // Byte complete flag: set on the eighth rise, used at next fall
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byte_ready_reg   <= 1'b0;
      wr_data_pend_reg <= 1'b0;
    end else begin
      if (start_det || stop_det) begin
        byte_ready_reg <= 1'b0;
      end else if (scl_rise && bit_reg == `RTSL_BIT_LAST &&
                   (state_reg == ST_ADDR || state_reg == ST_WBYTE)) begin
        byte_ready_reg <= 1'b1;
      end else if (scl_fall) begin
        byte_ready_reg <= 1'b0;
      end
      if (wr_strobe_next) begin
        wr_data_pend_reg <= 1'b1;
      end else if (state_reg == ST_WACK && scl_fall) begin
        wr_data_pend_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers and outputs
  // ------------------------------------------------------------
  // pins only sensed, released or pulled low, never clocked by us
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      bit_reg       <= 3'h0;
      ptr_done_reg  <= 1'b0;
      drive_low_reg <= 1'b0;
      reg_ptr       <= `RTSL_PTR_RESET;
      wr_data       <= 8'h00;
      wr_strobe     <= 1'b0;
      snap_strobe   <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_n      <= 1'b1;
      busy          <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_reg       <= bit_next;
      ptr_done_reg  <= ptr_done_next;
      drive_low_reg <= drive_low_next;
      reg_ptr       <= ptr_next;
      wr_data       <= wr_data_next;
      wr_strobe     <= wr_strobe_next;
      snap_strobe   <= start_det;
      // output level stays low; enable does the work
      sda_out       <= 1'b0;
      sda_oe_n      <= ~drive_low_next;
      busy          <= (state_next != ST_IDLE);
    end
  end

endmodule // rtsl_slave

// *** bench/rtsl_slave_chk.sv ***
// Concurrent checks on the ports of the two-wire slave.
// Assumes bus lines that move slowly against core_clk.
module rtsl_slave_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic [5:0] reg_ptr,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] wr_data,
  input wire logic       wr_strobe,
  input wire logic       snap_strobe,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic [5:0] ptr_at_wr;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det  = scl_in & scl_q & ~sda_q & sda_in;

  // Last samples of the raw lines, pointer seen at each commit
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      ptr_at_wr <= 6'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (wr_strobe) ptr_at_wr <= reg_ptr;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  AST_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_SNAP: assert property (start_det |-> ##[1:6] snap_strobe)
    else $error("no snapshot after start");
  AST_START_BUSY: assert property (start_det |-> ##[1:8] busy)
    else $error("start not seen");
  AST_STOP_IDLE: assert property (stop_det |-> ##[1:8] !busy)
    else $error("stop not seen");
  AST_CHG_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data pin moved while clock high");
  AST_PTR_INC: assert property (wr_strobe |->
    ##[2:40] reg_ptr == ptr_at_wr + 6'h01)
    else $error("pointer not advanced after write");
  AST_IDLE_REL: assert property (!busy && !$past(busy) |-> sda_oe_n)
    else $error("data pin pulled while idle");
  AST_COMMIT_ACK: assert property (wr_strobe |-> ##[0:4] !sda_oe_n)
    else $error("commit away from acknowledge");
  AST_STB_ONE: assert property (snap_strobe |=> !snap_strobe)
    else $error("snapshot pulse too long");
  AST_ACK_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
    else $error("pull low not held");
endmodule // rtsl_slave_chk

bind rtsl_slave rtsl_slave_chk rtsl_slave_chk_inst (.core_clk, .nrst,
  .scl_in, .sda_in, .sda_out, .sda_oe_n, .reg_ptr, .rd_data, .wr_data,
  .wr_strobe, .snap_strobe, .busy);

// *** bench/rtsl_master_model.sv ***
// Behavioural bus master facing the two-wire slave.
// Assumes an open-drain data wire with pull-up built by the bench.
module rtsl_master_model (
  input  wire logic       sda_line,
  output logic            scl_out,
  output logic            sda_oe_n,
  output logic            rx_stb,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_out  = 1'b1;
    sda_oe_n = 1'b1;
    rx_stb   = 1'b0;
    rx_byte  = 8'h00;
  end

  // scaled bit time; the slave times itself off core_clk only.
  // Steps are whole clock periods, so no line moves on a sampling edge
  task automatic bit_cycle(input logic d, output logic q);
    scl_out = 1'b0;
    #20 sda_oe_n = d;
    #30 scl_out = 1'b1;
    #30 q = sda_line;
  endtask

  task automatic start;
    wait (scl_out && sda_line);
    #40 sda_oe_n = 1'b0;
    #40;
  endtask

  task automatic rstart;
    scl_out = 1'b0;
    #20 sda_oe_n = 1'b1;
    #30 scl_out = 1'b1;
    #40 sda_oe_n = 1'b0;
    #40;
  endtask

  task automatic stop;
    scl_out = 1'b0;
    #20 sda_oe_n = 1'b0;
    #30 scl_out = 1'b1;
    #40 sda_oe_n = 1'b1;
    #80;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], q);
    bit_cycle(1'b1, q);
    ack = !q;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, q);
      b[i] = q;
    end
    bit_cycle(last, q);
    rx_byte = b;
    rx_stb  = 1'b1;
    #10 rx_stb = 1'b0;
  endtask
endmodule // rtsl_master_model

// *** bench/rtsl_slave_tb_top.sv ***
// Self-checking bench for the two-wire slave with a master model.
// Assumes the register file is a fixed random table here.
`include "rtsl_defs.vh"
module rtsl_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        scl;
  logic        m_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic [5:0]  reg_ptr;
  logic [7:0]  rd_data  = 8'h00;
  logic [7:0]  wr_data;
  logic        wr_strobe;
  logic        snap_strobe;
  logic        busy;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic [7:0]  mem [0:63];
  logic [14:0] exp_q [$];
  int          bad_count = 0;
  int          compares  = 0;
  // Pull-up wire: either party may only pull low
  wire sda = m_oe_n & (sda_oe_n | sda_out);

  always #5 core_clk = ~core_clk;
  // Register file answers at the falling edge
  always @(negedge core_clk) rd_data <= mem[reg_ptr];

  rtsl_slave rtsl_slave_inst (.core_clk(core_clk), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .reg_ptr(reg_ptr), .rd_data(rd_data), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .snap_strobe(snap_strobe), .busy(busy));
  rtsl_master_model rtsl_master_model_inst (.sda_line(sda),
    .scl_out(scl), .sda_oe_n(m_oe_n), .rx_stb(rx_stb), .rx_byte(rx_byte));

  task automatic chk(input logic [14:0] got, input logic [14:0] want);
    compares++;
    if (got !== want) begin
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
      bad_count++;
    end
  endtask
  task automatic bit_is(input logic got, input logic want);
    chk({14'h0000, got}, {14'h0000, want});
  endtask
  // An empty queue gives a note no result can match
  task automatic take(input logic [14:0] got);
    logic [14:0] w;
    w = 15'h7FFF;
    if (exp_q.size() != 0) w = exp_q.pop_front();
    chk(got, w);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Result watchers pair each result with the oldest note
  always @(negedge core_clk) begin
    if (wr_strobe === 1'b1) take({1'b0, reg_ptr, wr_data});
  end
  always @(posedge rx_stb) take({1'b1, 6'h00, rx_byte});

  // Run far longer than the sequence needs, then give up
  initial begin
    #100us;
    bad_count++;
    close_out();
  end

  initial begin
    logic       a;
    logic [7:0] d;
    logic [5:0] p;
    logic [6:0] ad;
    void'($urandom(32'hBEDF4978));
    foreach (mem[i]) mem[i] = 8'($urandom());
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (5) @(negedge core_clk);
    // Write burst that crosses the pointer wrap
    p = 6'h3E;
    d = 8'($urandom());
    d[5:0] = p;
    rtsl_master_model_inst.start();
    rtsl_master_model_inst.put_byte({`RTSL_SLAVE_ADDR, 1'b0}, a);
    bit_is(a, 1'b1);
    rtsl_master_model_inst.put_byte(d, a);
    bit_is(a, 1'b1);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom());
      exp_q.push_back({1'b0, p, d});
      p = p + 6'h01;
      rtsl_master_model_inst.put_byte(d, a);
      bit_is(a, 1'b1);
    end
    rtsl_master_model_inst.stop();
    // Read from the pointer the burst left behind
    rtsl_master_model_inst.start();
    rtsl_master_model_inst.put_byte({`RTSL_SLAVE_ADDR, 1'b1}, a);
    bit_is(a, 1'b1);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back({1'b1, 6'h00, mem[p]});
      p = p + 6'h01;
      rtsl_master_model_inst.get_byte(i == 2, d);
    end
    bit_is(sda_oe_n, 1'b1);
    rtsl_master_model_inst.stop();
    // Pointer only, then repeated start into a read
    p = 6'($urandom());
    rtsl_master_model_inst.start();
    rtsl_master_model_inst.put_byte({`RTSL_SLAVE_ADDR, 1'b0}, a);
    rtsl_master_model_inst.put_byte({2'b00, p}, a);
    bit_is(a, 1'b1);
    rtsl_master_model_inst.rstart();
    rtsl_master_model_inst.put_byte({`RTSL_SLAVE_ADDR, 1'b1}, a);
    bit_is(a, 1'b1);
    exp_q.push_back({1'b1, 6'h00, mem[p]});
    rtsl_master_model_inst.get_byte(1'b1, d);
    rtsl_master_model_inst.stop();
    // Foreign addresses of both directions are ignored
    for (int i = 0; i < 4; i++) begin
      ad = 7'($urandom());
      if (ad == `RTSL_SLAVE_ADDR) ad = ad ^ 7'h01;
      rtsl_master_model_inst.start();
      rtsl_master_model_inst.put_byte({ad, i[0]}, a);
      bit_is(a, 1'b0);
      rtsl_master_model_inst.put_byte({`RTSL_SLAVE_ADDR, 1'b0}, a);
      bit_is(a, 1'b0);
      rtsl_master_model_inst.stop();
      bit_is(busy, 1'b0);
    end
    chk(15'(exp_q.size()), 15'h0000);
    close_out();
  end
endmodule // rtsl_slave_tb_top
